/* rtl/modbus_ascii_slave_coil_read.sv */
// modbus ascii slave request handler with read-coils reply builder
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - accept only codes 01 to 06, 08, 15 and 16; 08 echoes data.
// - request addresses are zero based at message level.
// - register request crossing a data block gets exception code 02.
// - such a crossing also logs diagnostic code 0E39.
// - crossing check only when the 32-bit register option is off.
// - block holds registers 0..511; register n is word byte offset 2n.
// - read coils request addr/count; reply addr, code, byte count, data.
// - first bit address must fall in flag, output or db window.
// - byte index is (addr - low)/8 plus base, db adds no base.
// - start bit is the remainder of that division by eight.
// - bit count 1..2008, exactly that many consecutive bits read.
module modbus_ascii_slave_coil_read
  import modbus_slave_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // parsed request from the frame receiver
  input wire logic reqValid,
  input wire logic [7:0] reqSlaveAddr,
  input wire logic [7:0] functionCodeField,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqCount,
  // reply byte stream towards the frame sender
  output logic [7:0] txData,
  output logic txValid,
  output logic txLast,
  input wire logic txReady,
  // local bit memory, read data valid in the same cycle as memRd
  output logic memRd,
  output logic [1:0] memArea,
  output logic [15:0] memAddr,
  input wire logic [7:0] memRdata,
  // accepted requests handled elsewhere
  output logic fwdValid,
  output logic [7:0] fwdFunc,
  output logic [15:0] fwdAddr,
  output logic [15:0] fwdCount,
  output logic [6:0] fwdBlock,
  output logic [9:0] fwdByteOffset,
  output logic busy
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic isSupported(input logic [7:0] fc);
    unique case (fc)
      FC_READ_COILS, FC_READ_INPUTS, FC_READ_HOLDING, FC_READ_INPUT_REG,
      FC_WRITE_COIL, FC_WRITE_REG, FC_DIAG_ECHO, FC_WRITE_COILS,
      FC_WRITE_REGS: isSupported = 1'b1;
      default: isSupported = 1'b0;
    endcase
  endfunction

  function automatic logic isRegister(input logic [7:0] fc);
    isRegister = (fc == FC_READ_HOLDING) || (fc == FC_READ_INPUT_REG) ||
                 (fc == FC_WRITE_REG) || (fc == FC_WRITE_REGS);
  endfunction

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic reg32_q;
  logic [NUM_AREAS-1:0][15:0] areaLo_q;
  logic [NUM_AREAS-1:0][15:0] areaHi_q;
  logic [NUM_AREAS-1:0][15:0] areaBase_q;
  logic [15:0] diagCode_q;
  logic [15:0] diagCount_q;
  logic diagEvent;

  // software writes; db window has no base register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg32_q <= 1'b0;
      areaLo_q <= '{default: RST_BOUND};
      areaHi_q <= '{default: RST_HI};
      areaBase_q <= '{default: RST_BOUND};
    end else if (regWr) begin
      unique case (regAddr)
        ADDR_CTRL: reg32_q <= regWdata[CTRL_REG32_BIT];
        ADDR_FLAG_LO: areaLo_q[AREA_FLAG] <= regWdata[15:0];
        ADDR_FLAG_HI: areaHi_q[AREA_FLAG] <= regWdata[15:0];
        ADDR_FLAG_BASE: areaBase_q[AREA_FLAG] <= regWdata[15:0];
        ADDR_OUT_LO: areaLo_q[AREA_OUTPUT] <= regWdata[15:0];
        ADDR_OUT_HI: areaHi_q[AREA_OUTPUT] <= regWdata[15:0];
        ADDR_OUT_BASE: areaBase_q[AREA_OUTPUT] <= regWdata[15:0];
        ADDR_DB_LO: areaLo_q[AREA_DB] <= regWdata[15:0];
        ADDR_DB_HI: areaHi_q[AREA_DB] <= regWdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // diagnostic log: last code and event count
  // ----------------------------------------------------------------
  // a clear meeting a logged event in the same cycle restarts the count at one so none is lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      diagCode_q <= 16'h0000;
      diagCount_q <= 16'h0000;
    end else if (diagEvent) begin
      diagCode_q <= DIAG_DB_ACCESS;
      diagCount_q <= (regWr && regAddr == ADDR_DIAG) ? 16'h0001 :
                     diagCount_q + 16'h0001;
    end else if (regWr && regAddr == ADDR_DIAG) begin
      diagCount_q <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // read port, data in the cycle after the strobe
  // ----------------------------------------------------------------
  state_type state_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_CTRL: regRdata <= {31'h00000000, reg32_q};
        ADDR_FLAG_LO: regRdata <= {16'h0000, areaLo_q[AREA_FLAG]};
        ADDR_FLAG_HI: regRdata <= {16'h0000, areaHi_q[AREA_FLAG]};
        ADDR_FLAG_BASE: regRdata <= {16'h0000, areaBase_q[AREA_FLAG]};
        ADDR_OUT_LO: regRdata <= {16'h0000, areaLo_q[AREA_OUTPUT]};
        ADDR_OUT_HI: regRdata <= {16'h0000, areaHi_q[AREA_OUTPUT]};
        ADDR_OUT_BASE: regRdata <= {16'h0000, areaBase_q[AREA_OUTPUT]};
        ADDR_DB_LO: regRdata <= {16'h0000, areaLo_q[AREA_DB]};
        ADDR_DB_HI: regRdata <= {16'h0000, areaHi_q[AREA_DB]};
        ADDR_DIAG: regRdata <= {diagCount_q, diagCode_q};
        ADDR_STATUS: regRdata <= {28'h0000000, state_q, busy};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // latched request and conversion
  // ----------------------------------------------------------------
  logic [7:0] slave_q;
  logic [7:0] function_code_field_q;
  logic [15:0] addr_q;
  logic [15:0] count_q;
  logic convHit;
  logic [1:0] convArea;
  logic [15:0] convByte;
  logic [2:0] convBit;
  logic [16:0] lastReg;
  logic crossing;

  coil_addr_convert u_conv (
    .bitAddr(addr_q),
    .areaLo(areaLo_q),
    .areaHi(areaHi_q),
    .areaBase(areaBase_q),
    .hit(convHit),
    .area(convArea),
    .byteIndex(convByte),
    .bitPos(convBit)
  );

  // last register touched; block number is the bits above 511
  assign lastReg = {1'b0, addr_q} + {1'b0, count_q} - 17'h00001;
  // only standard mode can straddle two blocks
  assign crossing = !reg32_q && (count_q != 16'h0000) &&
                    (lastReg[16:REG_BLOCK_BITS] !=
                     {1'b0, addr_q[15:REG_BLOCK_BITS]});
  assign diagEvent = (state_q == ST_EVAL) && isSupported(function_code_field_q) &&
                     isRegister(function_code_field_q) && crossing;

  // ----------------------------------------------------------------
  // request handler and reply builder
  // ----------------------------------------------------------------
  logic [5:0][7:0] hdr_q;
  logic [2:0] hdrLen_q;
  logic [2:0] hdrIdx_q;
  logic coil_q;
  logic [2:0] bitPos_q;
  logic [7:0] bytesLeft_q;
  logic [15:0] bitsLeft_q;
  logic [7:0] prev_q;
  logic [7:0] cur_q;
  logic firstFetch_q;
  logic [15:0] shifted;
  logic [7:0] dataMask;

  // rebuild one reply byte from two neighbouring memory bytes
  assign shifted = {memRdata, prev_q} >> bitPos_q;
  // bits past the count are forced to zero
  assign dataMask = (bitsLeft_q >= 16'h0008) ? 8'hFF :
                    8'((9'h001 << bitsLeft_q[2:0]) - 9'h001);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      slave_q <= 8'h00;
      function_code_field_q <= 8'h00;
      addr_q <= 16'h0000;
      count_q <= 16'h0000;
      hdr_q <= '{default: 8'h00};
      hdrLen_q <= 3'h0;
      hdrIdx_q <= 3'h0;
      coil_q <= 1'b0;
      bitPos_q <= 3'h0;
      bytesLeft_q <= 8'h00;
      bitsLeft_q <= 16'h0000;
      prev_q <= 8'h00;
      cur_q <= 8'h00;
      firstFetch_q <= 1'b0;
      txData <= 8'h00;
      txValid <= 1'b0;
      txLast <= 1'b0;
      memRd <= 1'b0;
      memArea <= AREA_FLAG;
      memAddr <= 16'h0000;
      fwdValid <= 1'b0;
      fwdFunc <= 8'h00;
      fwdAddr <= 16'h0000;
      fwdCount <= 16'h0000;
      fwdBlock <= 7'h00;
      fwdByteOffset <= 10'h000;
      busy <= 1'b0;
    end else begin
      memRd <= 1'b0;
      fwdValid <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          busy <= 1'b0;
          if (reqValid) begin
            // addresses taken as zero based, no user offset
            slave_q <= reqSlaveAddr;
            function_code_field_q <= functionCodeField;
            addr_q <= reqAddr;
            count_q <= reqCount;
            busy <= 1'b1;
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          hdrIdx_q <= 3'h0;
          coil_q <= 1'b0;
          hdr_q[0] <= slave_q;
          hdr_q[1] <= function_code_field_q | FC_EXC_FLAG;
          hdrLen_q <= 3'h3;
          state_q <= ST_HDR;
          if (!isSupported(function_code_field_q)) begin
            hdr_q[2] <= EXC_ILLEGAL_FUNCTION_CODE_FIELD;
          end else if (isRegister(function_code_field_q) && crossing) begin
            hdr_q[2] <= EXC_ILLEGAL_ADDR;
          end else if (function_code_field_q == FC_DIAG_ECHO) begin
            // echo the received data back unchanged
            hdr_q[1] <= function_code_field_q;
            hdr_q[2] <= addr_q[15:8];
            hdr_q[3] <= addr_q[7:0];
            hdr_q[4] <= count_q[15:8];
            hdr_q[5] <= count_q[7:0];
            hdrLen_q <= 3'h6;
          end else if (function_code_field_q == FC_READ_COILS) begin
            if (count_q < COIL_COUNT_MIN || count_q > COIL_COUNT_MAX) begin
              hdr_q[2] <= EXC_ILLEGAL_VALUE;
            end else if (!convHit) begin
              hdr_q[2] <= EXC_ILLEGAL_ADDR;
            end else begin
              // reply: slave, code, byte count then data
              hdr_q[1] <= function_code_field_q;
              hdr_q[2] <= 8'((count_q + 16'h0007) >> 3);
              bytesLeft_q <= 8'((count_q + 16'h0007) >> 3);
              bitsLeft_q <= count_q;
              coil_q <= 1'b1;
              bitPos_q <= convBit;
              memArea <= convArea;
              memAddr <= convByte;
            end
          end else begin
            // accepted request for another handler
            fwdValid <= 1'b1;
            fwdFunc <= function_code_field_q;
            fwdAddr <= addr_q;
            fwdCount <= count_q;
            fwdBlock <= addr_q[15:REG_BLOCK_BITS];
            fwdByteOffset <= {addr_q[REG_BLOCK_BITS-1:0], 1'b0};
            state_q <= ST_IDLE;
          end
        end
        ST_HDR: begin
          if (!txValid) begin
            txData <= hdr_q[hdrIdx_q];
            txValid <= 1'b1;
            txLast <= !coil_q && (hdrIdx_q == hdrLen_q - 3'h1);
          end else if (txReady) begin
            txValid <= 1'b0;
            txLast <= 1'b0;
            hdrIdx_q <= hdrIdx_q + 3'h1;
            if (hdrIdx_q == hdrLen_q - 3'h1) begin
              state_q <= coil_q ? ST_PRIME : ST_IDLE;
            end
          end
        end
        ST_PRIME: begin
          memRd <= 1'b1;
          firstFetch_q <= 1'b1;
          state_q <= ST_FETCH;
        end
        ST_FETCH: begin
          // one extra byte is always read ahead of the reply byte
          if (firstFetch_q) begin
            prev_q <= memRdata;
          end
          firstFetch_q <= 1'b0;
          memRd <= 1'b1;
          memAddr <= memAddr + 16'h0001;
          state_q <= ST_SEND;
        end
        ST_SEND: begin
          if (!txValid) begin
            cur_q <= memRdata;
            txData <= shifted[7:0] & dataMask; // lsb first
            txValid <= 1'b1;
            txLast <= (bytesLeft_q == 8'h01);
          end else if (txReady) begin
            txValid <= 1'b0;
            txLast <= 1'b0;
            prev_q <= cur_q;
            bytesLeft_q <= bytesLeft_q - 8'h01;
            bitsLeft_q <= bitsLeft_q - 16'h0008;
            state_q <= (bytesLeft_q == 8'h01) ? ST_IDLE : ST_FETCH;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* rtl/modbus_slave_pkg.sv */
// shared constants for the modbus ascii slave request handler
package modbus_slave_pkg;

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_READ_COILS = 8'h01;
  localparam logic [7:0] FC_READ_INPUTS = 8'h02;
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT_REG = 8'h04;
  localparam logic [7:0] FC_WRITE_COIL = 8'h05;
  localparam logic [7:0] FC_WRITE_REG = 8'h06;
  localparam logic [7:0] FC_DIAG_ECHO = 8'h08;
  localparam logic [7:0] FC_WRITE_COILS = 8'h0F;
  localparam logic [7:0] FC_WRITE_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;

  // ----------------------------------------------------------------
  // exception and diagnostic codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION_CODE_FIELD = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] DIAG_DB_ACCESS = 16'h0E39;

  // ----------------------------------------------------------------
  // limits and layout
  // ----------------------------------------------------------------
  localparam logic [15:0] COIL_COUNT_MIN = 16'h0001;
  localparam logic [15:0] COIL_COUNT_MAX = 16'h07D8; // 2008 bits
  localparam int REG_BLOCK_BITS = 9;  // 512 registers, numbers 0..511
  localparam int BITS_PER_BYTE_LOG2 = 3;
  localparam int NUM_AREAS = 3;
  localparam logic [1:0] AREA_FLAG = 2'h0;
  localparam logic [1:0] AREA_OUTPUT = 2'h1;
  localparam logic [1:0] AREA_DB = 2'h2;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FLAG_LO = 8'h04;
  localparam logic [7:0] ADDR_FLAG_HI = 8'h08;
  localparam logic [7:0] ADDR_FLAG_BASE = 8'h0C;
  localparam logic [7:0] ADDR_OUT_LO = 8'h10;
  localparam logic [7:0] ADDR_OUT_HI = 8'h14;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h18;
  localparam logic [7:0] ADDR_DB_LO = 8'h1C;
  localparam logic [7:0] ADDR_DB_HI = 8'h20;
  localparam logic [7:0] ADDR_DIAG = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam int CTRL_REG32_BIT = 0;
  localparam logic [15:0] RST_BOUND = 16'h0000;
  localparam logic [15:0] RST_HI = 16'hFFFF;

  // ----------------------------------------------------------------
  // handler states, gray along the main path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EVAL = 3'b001,
    ST_HDR = 3'b011,
    ST_PRIME = 3'b010,
    ST_FETCH = 3'b110,
    ST_SEND = 3'b111
  } state_type;

endpackage

/* rtl/coil_addr_convert.sv */
// bit address to area, byte index and bit position conversion
`timescale 1ns/1ps

module coil_addr_convert
  import modbus_slave_pkg::*;
(
  input wire logic [15:0] bitAddr,
  input wire logic [NUM_AREAS-1:0][15:0] areaLo,
  input wire logic [NUM_AREAS-1:0][15:0] areaHi,
  input wire logic [NUM_AREAS-1:0][15:0] areaBase,
  output logic hit,
  output logic [1:0] area,
  output logic [15:0] byteIndex,
  output logic [2:0] bitPos
);

  // ----------------------------------------------------------------
  // per-area match and offset
  // ----------------------------------------------------------------
  logic [NUM_AREAS-1:0] match;
  logic [NUM_AREAS-1:0][15:0] offs;

  generate
    for (genvar i = 0; i < NUM_AREAS; i++) begin : g_area
      // window check before any access is made
      assign match[i] = (bitAddr >= areaLo[i]) && (bitAddr <= areaHi[i]);
      assign offs[i] = bitAddr - areaLo[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // priority select, lowest area wins on overlap
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    area = AREA_FLAG;
    byteIndex = 16'h0000;
    bitPos = 3'h0;
    for (int i = NUM_AREAS - 1; i >= 0; i--) begin
      if (match[i]) begin
        hit = 1'b1;
        area = 2'(i);
        // truncating divide plus base; db area gets no base
        byteIndex = (offs[i] >> BITS_PER_BYTE_LOG2) +
                    ((2'(i) == AREA_DB) ? 16'h0000 : areaBase[i]);
        bitPos = offs[i][2:0]; // remainder of the same division
      end
    end
  end

endmodule

/* tb/modbus_slave_props.sv */
// port assertions for the modbus request handler
`timescale 1ns/1ps

module modbus_slave_props
  import modbus_slave_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reqValid,
  input wire logic [7:0] reqSlaveAddr,
  input wire logic [7:0] functionCodeField,
  input wire logic [15:0] reqCount,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txLast,
  input wire logic txReady,
  input wire logic fwdValid,
  input wire logic [7:0] fwdFunc,
  input wire logic busy
);
  // --------------------
  // reply tracking
  // --------------------
  logic [7:0] slave_q;
  logic [7:0] code_q;
  logic [15:0] cnt_q;
  logic [15:0] idx_q;
  logic coilOk_q;
  logic unsup;
  assign unsup = !(code_q inside {FC_READ_COILS, FC_READ_INPUTS,
    FC_READ_HOLDING, FC_READ_INPUT_REG, FC_WRITE_COIL, FC_WRITE_REG,
    FC_DIAG_ECHO, FC_WRITE_COILS, FC_WRITE_REGS});
  // latch the request, index the accepted reply bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slave_q <= 8'h00;
      code_q <= 8'h00;
      cnt_q <= 16'h0000;
      idx_q <= 16'h0000;
      coilOk_q <= 1'b0;
    end else if (reqValid && !busy) begin
      slave_q <= reqSlaveAddr;
      code_q <= functionCodeField;
      cnt_q <= reqCount;
      idx_q <= 16'h0000;
      coilOk_q <= 1'b0;
    end else if (txValid && txReady) begin
      idx_q <= idx_q + 16'h0001;
      if (idx_q == 16'h0001 && txData == FC_READ_COILS) begin
        coilOk_q <= 1'b1;
      end
    end
  end
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence sTake;
    reqValid && !busy;
  endsequence
  sequence sHold;
    txValid && !txReady;
  endsequence
  AST_TAKE_BUSY: assert property (sTake |=> busy)
    else $error("busy not raised");
  AST_FIRST_BYTE: assert property (sTake ##0
    (functionCodeField == FC_READ_COILS) |-> ##3 txValid)
    else $error("reply not started");
  AST_HDR_SLAVE: assert property (
    txValid && idx_q == 16'h0000 |-> txData == slave_q)
    else $error("bad slave byte");
  AST_TX_HOLD: assert property (sHold |=>
    txValid && $stable(txData) && $stable(txLast))
    else $error("byte changed in stall");
  AST_TX_GAP: assert property (txValid && txReady |=> !txValid)
    else $error("no gap after byte");
  AST_UNSUP_CODE: assert property (
    txValid && idx_q == 16'h0001 && unsup |-> txData == (code_q | FC_EXC_FLAG))
    else $error("code not flagged");
  AST_UNSUP_LAST: assert property (
    txValid && idx_q == 16'h0002 && unsup |->
    txLast && txData == EXC_ILLEGAL_FUNCTION_CODE_FIELD)
    else $error("bad exception 01");
  AST_COUNT_RANGE: assert property (txValid &&
    idx_q == 16'h0001 && code_q == FC_READ_COILS &&
    (cnt_q == 16'h0000 || cnt_q > COIL_COUNT_MAX) |-> txData == 8'h81)
    else $error("count not refused");
  AST_BYTE_COUNT: assert property (
    txValid && idx_q == 16'h0002 && coilOk_q |->
    txData == 8'((cnt_q + 16'h0007) >> 3))
    else $error("bad byte count");
  AST_LAST_POS: assert property (
    txValid && txLast && coilOk_q |->
    idx_q == 16'h0002 + ((cnt_q + 16'h0007) >> 3))
    else $error("bad reply length");
  AST_FWD_CODE: assert property (
    fwdValid |-> fwdFunc == code_q && !unsup && !txValid)
    else $error("bad forward code");
endmodule

bind modbus_ascii_slave_coil_read modbus_slave_props u_props (
  .clk(clk), .reset_n(reset_n), .reqValid(reqValid),
  .reqSlaveAddr(reqSlaveAddr), .functionCodeField(functionCodeField),
  .reqCount(reqCount), .txData(txData), .txValid(txValid),
  .txLast(txLast), .txReady(txReady), .fwdValid(fwdValid),
  .fwdFunc(fwdFunc), .busy(busy)
);

/* tb/link_master_model.sv */
// far side model: stalling reply sink and local bit memory
`timescale 1ns/1ps

module link_master_model (
  input wire logic stall,
  input wire logic txValid,
  output logic txReady,
  input wire logic memRd,
  input wire logic [1:0] memArea,
  input wire logic [15:0] memAddr,
  output logic [7:0] memRdata
);
  // stalls prove that a reply byte is held until taken
  assign txReady = txValid && !stall;
  // answers at once; idle inverts, so a stale sample shows
  assign memRdata = {8{!memRd}} ^ memAddr[7:0] ^ memAddr[15:8] ^ {4{memArea}};
endmodule

/* tb/modbus_ascii_slave_coil_read_tb_top.sv */
// self-checking bench for the modbus request handler
`timescale 1ns/1ps

module modbus_ascii_slave_coil_read_tb_top
  import modbus_slave_pkg::*;
;
  logic clk, reset_n, regWr, regRd, reqValid, txValid, txLast, txReady;
  logic memRd, fwdValid, busy, stall;
  logic [7:0] regAddr, reqSlaveAddr, functionCodeField, txData, sl;
  logic [7:0] memRdata, fwdFunc;
  logic [31:0] regWdata, regRdata, lfsr, stallLfsr;
  logic [15:0] reqAddr, reqCount, memAddr, fwdAddr, fwdCount, ra;
  logic [1:0] memArea;
  logic [6:0] fwdBlock;
  logic [9:0] fwdByteOffset;
  logic [7:0] rx[$], ex[$];
  int n_errors, checks_done, cycles;
  int wl[3] = '{0, 2048, 4096}, wh[3] = '{2047, 2559, 4607};
  int wb[3] = '{1000, 256, 0};
  int cAddr[8] = '{0, 33, 1024, 1542, 2112, 2532, 4112, 4290};
  int cCnt[8] = '{1, 7, 8, 9, 32, 2008, 17, 64};
  logic [7:0] uc[7] = '{8'h00, 8'h07, 8'h09, 8'h0E, 8'h11, 8'h2B, 8'h81};
  logic [7:0] oc[7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10};

  modbus_ascii_slave_coil_read u_dut (.clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .reqValid(reqValid), .reqSlaveAddr(reqSlaveAddr),
    .functionCodeField(functionCodeField), .reqAddr(reqAddr),
    .reqCount(reqCount), .txData(txData), .txValid(txValid),
    .txLast(txLast), .txReady(txReady), .memRd(memRd), .memArea(memArea),
    .memAddr(memAddr), .memRdata(memRdata), .fwdValid(fwdValid),
    .fwdFunc(fwdFunc), .fwdAddr(fwdAddr), .fwdCount(fwdCount),
    .fwdBlock(fwdBlock), .fwdByteOffset(fwdByteOffset), .busy(busy));
  link_master_model u_far (.stall(stall),
    .txValid(txValid), .txReady(txReady), .memRd(memRd),
    .memArea(memArea), .memAddr(memAddr), .memRdata(memRdata));

  // --------------------
  // helpers
  // --------------------
  function automatic logic [31:0] lfsrStep(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] pat(input int ar, input int ad);
    return 8'(ad) ^ 8'(ad >> 8) ^ {4{2'(ar)}};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regRead(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    check("regRdata", regRdata, e);
    @(posedge clk);
  endtask
  // wait for idle: a request outside ST_IDLE is dropped
  task automatic request(input logic [7:0] fc, input logic [15:0] a, c);
    int w;
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (busy !== 1'b0 && w < 50);
    check("busy", busy, 0);
    @(posedge clk);
    lfsr = lfsrStep(lfsr);
    sl = lfsr[7:0];
    reqSlaveAddr <= sl;
    functionCodeField <= fc;
    reqAddr <= a;
    reqCount <= c;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
  endtask
  task automatic getReply(input string what);
    int w;
    w = 0;
    rx.delete();
    while (w < 2000) begin
      @(negedge clk);
      w++;
      if (txValid === 1'b1 && txReady === 1'b1) begin
        rx.push_back(txData);
        if (txLast === 1'b1) break;
      end
    end
    @(posedge clk);
    check({what, " len"}, rx.size(), ex.size());
    foreach (ex[i]) if (i < rx.size()) check(what, rx[i], ex[i]);
  endtask
  // expected coil reply from the window table and the memory pattern
  task automatic coil(input logic [15:0] a, c);
    int k, off;
    logic [7:0] d, p;
    request(FC_READ_COILS, a, c);
    k = 3;
    for (int m = 2; m >= 0; m--) if (a >= wl[m] && a <= wh[m]) k = m;
    if (c == 0 || c > COIL_COUNT_MAX) ex = {sl, 8'h81, EXC_ILLEGAL_VALUE};
    else if (k == 3) ex = {sl, 8'h81, EXC_ILLEGAL_ADDR};
    else begin
      ex = {sl, FC_READ_COILS, 8'((c + 7) / 8)};
      for (int j = 0; j < (c + 7) / 8; j++) begin
        d = 8'h00;
        for (int b = 0; b < 8; b++) begin
          off = a - wl[k] + 8 * j + b;
          p = pat(k, off / 8 + (k == 2 ? 0 : wb[k]));
          if (8 * j + b < c) d[b] = p[off % 8];
        end
        ex.push_back(d);
      end
    end
    getReply("coil reply");
  endtask
  task automatic fwd(input logic [7:0] fc, input logic [15:0] a, c);
    int w;
    w = 0;
    request(fc, a, c);
    while (fwdValid !== 1'b1 && w < 10) begin
      @(negedge clk);
      w++;
    end
    check("fwdValid", fwdValid, 1);
    check("fwdFunc", fwdFunc, fc);
    check("fwdAddr", fwdAddr, a);
    check("fwdCount", fwdCount, c);
    check("fwdBlock", fwdBlock, a >> 9);
    check("fwdByteOffset", fwdByteOffset, (a & 511) * 2);
  endtask

  // --------------------
  // clock, stall pattern and hang guard
  // --------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    stallLfsr <= lfsrStep(stallLfsr);
    stall <= stallLfsr[0] & stallLfsr[5];
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  // --------------------
  // main sequence
  // --------------------
  initial begin
    {reset_n, regWr, regRd, reqValid} = '0;
    {regAddr, regWdata, reqSlaveAddr, functionCodeField} = '0;
    {reqAddr, reqCount} = '0;
    lfsr = 32'hD0E7857C;
    stallLfsr = 32'hD0E7857C;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    regRead(ADDR_CTRL, 32'h0);
    regRead(ADDR_FLAG_HI, 32'h0000FFFF);
    regRead(ADDR_DIAG, 32'h0);
    regRead(8'h3C, 32'h0);
    for (int m = 0; m < 3; m++) begin
      regWrite(ADDR_FLAG_LO + 8'(12 * m), wl[m]);
      regWrite(ADDR_FLAG_HI + 8'(12 * m), wh[m]);
      if (m < 2) regWrite(ADDR_FLAG_BASE + 8'(12 * m), wb[m]);
    end
    regRead(ADDR_OUT_BASE, 32'd256);
    foreach (cAddr[i]) coil(cAddr[i], cCnt[i]);
    repeat (12) begin
      lfsr = lfsrStep(lfsr);
      coil(lfsr[15:0] % 4700, lfsr[31:24] + 1);
    end
    coil(16'd2559, 16'd0);
    coil(16'd5, 16'd2009);
    coil(16'd3000, 16'd5);
    foreach (uc[i]) begin
      request(uc[i], 16'h0040, 16'h0020);
      ex = {sl, uc[i] | FC_EXC_FLAG, EXC_ILLEGAL_FUNCTION_CODE_FIELD};
      getReply("unsupported");
    end
    lfsr = lfsrStep(lfsr);
    ra = lfsr[15:0];
    request(FC_DIAG_ECHO, ra, ~ra);
    ex = {sl, FC_DIAG_ECHO, ra[15:8], ra[7:0], ~ra[15:8], ~ra[7:0]};
    getReply("echo");
    foreach (oc[i]) fwd(oc[i], lfsr[15:0] + 16'(i * 777), 16'd1);
    request(FC_READ_HOLDING, 16'd510, 16'd3);
    ex = {sl, 8'h83, EXC_ILLEGAL_ADDR};
    getReply("crossing");
    regRead(ADDR_DIAG, {16'h0001, DIAG_DB_ACCESS});
    fwd(FC_READ_HOLDING, 16'd510, 16'd2);
    request(FC_WRITE_REGS, 16'd1023, 16'd2);
    ex = {sl, 8'h90, EXC_ILLEGAL_ADDR};
    getReply("crossing");
    regRead(ADDR_DIAG, {16'h0002, DIAG_DB_ACCESS});
    regWrite(ADDR_CTRL, 32'h1);
    fwd(FC_READ_HOLDING, 16'd510, 16'd3);
    complete_run();
  end
endmodule
